// ### pbx_pkg.sv
package pbx_pkg;
    localparam int          UpperWidth = 32;
    localparam int          UpperCbeWidth = 4;
    localparam logic [3:0]  CmdDualAddr = 4'hd;
    localparam logic        LevelHigh = 1'h1;
    localparam logic        LevelLow = 1'h0;
    localparam logic [31:0] ParkData = 32'h0;
    localparam logic [3:0]  ParkCbe = 4'h0;

    typedef enum logic [2:0] {
        PbxIdle,
        PbxAddr1,
        PbxAddr2,
        PbxData,
        PbxTurn
    } pbx_state_t;
endpackage

// ### pbx_ext64.sv
`timescale 1ns/1ps
// Overview of operation
// RQ1: dual address puts upper address high
// RQ2: otherwise upper lines held valid levels
// RQ3: wide data phase: writer drives upper data
// RQ4: dual address puts command on upper lines
// RQ5: initiator drives upper byte enables
// RQ6: upper parity is even over lines
// RQ7: parity valid after each address phase
// RQ8: parity driven one clock after data
// RQ9: parity released one clock after data
// RQ10: receiver checks upper parity
// RQ11: wide request follows frame timing
// RQ12: request low at reset enables width
// RQ13: no width: device parks upper lines
// RQ14: request driven high one clock first
// RQ15: acknowledge only while request asserted
// RQ16: acknowledge follows device-select timing
// RQ17: acknowledge driven high one clock first
module pbx_ext64 #(
    parameter int DataWidth = 32,
    parameter int CbeWidth  = 4
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    // initiator side from bridge core
    input  wire logic                 mstFrameN,
    input  wire logic                 mstWantWide,
    input  wire logic                 mstDualAddr,
    input  wire logic                 mstAddrPhase,
    input  wire logic                 mstSecondAddr,
    input  wire logic                 mstDataPhase,
    input  wire logic                 mstWrite,
    input  wire logic [DataWidth-1:0] mstUpperAddr,
    input  wire logic [CbeWidth-1:0]  mstCommand,
    input  wire logic [DataWidth-1:0] mstUpperWrData,
    input  wire logic [CbeWidth-1:0]  mstUpperBe,
    // target side from bridge core
    input  wire logic                 tgtDevselN,
    input  wire logic                 tgtCanWide,
    input  wire logic                 tgtReadPhase,
    input  wire logic [DataWidth-1:0] tgtUpperRdData,
    input  wire logic                 busGnt,
    input  wire logic                 busIdle,
    input  wire logic                 dataXfer,
    // pins
    input  wire logic [DataWidth-1:0] adUpperIn,
    output logic      [DataWidth-1:0] adUpperOut,
    output logic                      adUpperOe,
    input  wire logic [CbeWidth-1:0]  cbeUpperIn,
    output logic      [CbeWidth-1:0]  primary_upper_cmd_byte_en,
    output logic                      cbeUpperOe,
    input  wire logic                 parUpperIn,
    output logic                      primary_upper_parity,
    output logic                      parUpperOe,
    input  wire logic                 wideReqNIn,
    output logic                      primary_wide_request_n,
    output logic                      wideReqOe,
    input  wire logic                 wideAckNIn,
    input  wire logic                 primary_devsel_n,
    output logic                      primary_wide_ack_n,
    output logic                      wideAckOe,
    // status to core
    output logic                      wideEnabled,
    output logic                      upperParErr,
    output logic                      wideActive,
    output logic [DataWidth-1:0]      rdUpperData
);
    function automatic logic evenPar(input logic [DataWidth-1:0] d,
                                     input logic [CbeWidth-1:0]  c);
        evenPar = ^{d, c};
    endfunction

    logic                  rstSeen_q;
    logic                  wideEn_q;
    logic                  reqN_q;
    logic                  ackN_q;
    logic                  drive_q;
    logic                  parOe_q;
    logic [DataWidth-1:0]  adOut_q;
    logic [CbeWidth-1:0]   cbeOut_q;
    logic                  cbeOe_q;
    logic                  par_q;
    logic                  reqOe_q;
    logic                  ackOe_q;
    logic                  chk_q;
    logic                  perr_q;
    logic [DataWidth-1:0]  rdData_q;
    logic [DataWidth-1:0]  adRx_q;
    logic [CbeWidth-1:0]   cbeRx_q;
    pbx_pkg::pbx_state_t   st_q;
    logic                  wideNow;
    logic                  mstWide;
    logic                  tgtWide;
    logic                  active_q;
    logic [CbeWidth-1:0]   cbeBus;

    assign wideNow = !wideReqNIn && !wideAckNIn;
    assign mstWide = wideEn_q && mstWantWide;
    // RQ15 only answer a request
    assign tgtWide = wideEn_q && tgtCanWide && !wideReqNIn;
    // parity covers the upper enables as they stand on the pins
    assign cbeBus  = cbeOe_q ? cbeOut_q : cbeUpperIn;

    // ---------------------------------------------
    // reset strap
    // ---------------------------------------------
    // RQ12 sample strap while reset held
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wideEn_q <= !wideReqNIn;
        end
    end

    // parking drive starts at the second edge after release
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstSeen_q <= pbx_pkg::LevelLow;
        end
        else
        begin
            rstSeen_q <= pbx_pkg::LevelHigh;
        end
    end

    // ---------------------------------------------
    // wide request and acknowledge
    // ---------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reqN_q  <= pbx_pkg::LevelHigh;
            reqOe_q <= pbx_pkg::LevelLow;
        end
        else
        begin
            // RQ11 mirror frame
            reqN_q  <= !(mstWide && !mstFrameN);
            // RQ14 drive high one clock then float
            reqOe_q <= (mstWide && !mstFrameN) || !reqN_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ackN_q  <= pbx_pkg::LevelHigh;
            ackOe_q <= pbx_pkg::LevelLow;
        end
        else
        begin
            // RQ16 mirror device select
            ackN_q  <= !(tgtWide && !tgtDevselN);
            // RQ17 drive high one clock then float
            ackOe_q <= (tgtWide && !tgtDevselN) || !ackN_q;
        end
    end

    // ---------------------------------------------
    // upper address, data and command drive
    // ---------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            adOut_q  <= pbx_pkg::ParkData;
            cbeOut_q <= pbx_pkg::ParkCbe;
            drive_q  <= pbx_pkg::LevelLow;
            cbeOe_q  <= pbx_pkg::LevelLow;
            st_q     <= pbx_pkg::PbxIdle;
            active_q <= pbx_pkg::LevelLow;
        end
        else if (mstAddrPhase)
        begin
            st_q    <= mstSecondAddr ? pbx_pkg::PbxAddr2
                                     : pbx_pkg::PbxAddr1;
            drive_q <= pbx_pkg::LevelHigh;
            cbeOe_q <= pbx_pkg::LevelHigh;
            active_q <= pbx_pkg::LevelLow;
            // RQ1 upper address on dual cycle
            // RQ4 command on upper lines
            if (mstWide && mstDualAddr && !mstSecondAddr)
            begin
                adOut_q  <= mstUpperAddr;
                cbeOut_q <= mstCommand;
            end
            else
            begin
                // RQ2 stable defined levels
                adOut_q  <= pbx_pkg::ParkData;
                cbeOut_q <= pbx_pkg::ParkCbe;
            end
        end
        else if (mstDataPhase && mstWide && wideNow)
        begin
            st_q     <= pbx_pkg::PbxData;
            active_q <= pbx_pkg::LevelHigh;
            // RQ3 initiator write data
            adOut_q  <= mstWrite ? mstUpperWrData : pbx_pkg::ParkData;
            drive_q  <= mstWrite;
            // RQ5 upper byte enables
            cbeOut_q <= mstUpperBe;
            cbeOe_q  <= pbx_pkg::LevelHigh;
        end
        else if (tgtReadPhase && tgtWide && wideNow)
        begin
            st_q     <= pbx_pkg::PbxData;
            active_q <= pbx_pkg::LevelHigh;
            // RQ3 target read data
            adOut_q  <= tgtUpperRdData;
            drive_q  <= pbx_pkg::LevelHigh;
            cbeOe_q  <= pbx_pkg::LevelLow;
        end
        else if (!wideEn_q || (busIdle && busGnt))
        begin
            // RQ13 park when narrow or granted idle
            st_q     <= pbx_pkg::PbxIdle;
            active_q <= pbx_pkg::LevelLow;
            adOut_q  <= pbx_pkg::ParkData;
            cbeOut_q <= pbx_pkg::ParkCbe;
            drive_q  <= rstSeen_q;
            cbeOe_q  <= rstSeen_q;
        end
        else
        begin
            st_q    <= (st_q == pbx_pkg::PbxIdle) ? pbx_pkg::PbxIdle
                                                  : pbx_pkg::PbxTurn;
            drive_q <= pbx_pkg::LevelLow;
            cbeOe_q <= pbx_pkg::LevelLow;
            active_q <= pbx_pkg::LevelLow;
        end
    end

    // ---------------------------------------------
    // upper parity
    // ---------------------------------------------
    // RQ6 even over data and enables
    // RQ7 RQ8 one clock behind lines
    // RQ9 release one clock after lines
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            par_q   <= pbx_pkg::LevelLow;
            parOe_q <= pbx_pkg::LevelLow;
        end
        else
        begin
            par_q   <= evenPar(adOut_q, cbeBus);
            parOe_q <= drive_q;
        end
    end

    // ---------------------------------------------
    // receive parity check
    // ---------------------------------------------
    // RQ10 compare one clock after data
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            adRx_q   <= pbx_pkg::ParkData;
            cbeRx_q  <= pbx_pkg::ParkCbe;
            chk_q    <= pbx_pkg::LevelLow;
            perr_q   <= pbx_pkg::LevelLow;
            rdData_q <= pbx_pkg::ParkData;
        end
        else
        begin
            adRx_q  <= adUpperIn;
            cbeRx_q <= cbeUpperIn;
            chk_q   <= wideEn_q && wideNow && dataXfer && !drive_q;
            perr_q  <= chk_q && (evenPar(adRx_q, cbeRx_q) != parUpperIn);
            if (wideEn_q && wideNow && dataXfer && !drive_q)
            begin
                rdData_q <= adUpperIn;
            end
        end
    end

    // ---------------------------------------------
    // pin and status outputs
    // ---------------------------------------------
    // all outputs straight from flops
    assign adUpperOut                = adOut_q;
    assign adUpperOe                 = drive_q;
    assign primary_upper_cmd_byte_en = cbeOut_q;
    assign cbeUpperOe                = cbeOe_q;
    assign primary_upper_parity      = par_q;
    assign parUpperOe                = parOe_q;
    assign primary_wide_request_n    = reqN_q;
    assign wideReqOe                 = reqOe_q;
    assign primary_wide_ack_n        = ackN_q;
    assign wideAckOe                 = ackOe_q;
    assign wideEnabled               = wideEn_q;
    assign upperParErr               = perr_q;
    assign wideActive                = active_q;
    assign rdUpperData               = rdData_q;
endmodule // pbx_ext64

// ### pbx_ext64_asserts.sv
`timescale 1ns/1ps
module pbx_ext64_asserts (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        mstFrameN,
    input wire logic        tgtDevselN,
    input wire logic        wideReqNIn,
    input wire logic [31:0] adUpperOut,
    input wire logic        adUpperOe,
    input wire logic [3:0]  cbeUpperIn,
    input wire logic        cbeUpperOe,
    input wire logic [3:0]  primary_upper_cmd_byte_en,
    input wire logic        primary_upper_parity,
    input wire logic        parUpperOe,
    input wire logic        primary_wide_request_n,
    input wire logic        wideReqOe,
    input wire logic        primary_wide_ack_n,
    input wire logic        wideAckOe,
    input wire logic        wideEnabled
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    logic [3:0] cbeBus;
    assign cbeBus = cbeUpperOe ? primary_upper_cmd_byte_en : cbeUpperIn;
    property p_par_even;
        parUpperOe && $past(adUpperOe) |-> primary_upper_parity ==
            ^{$past(adUpperOut), $past(cbeBus)};
    endproperty
    a_par_even: assert property (p_par_even)
        else $error("upper parity wrong");
    property p_par_rel;
        wideEnabled && $fell(adUpperOe) |-> parUpperOe ##1 !parUpperOe;
    endproperty
    a_par_rel: assert property (p_par_rel) else $error("parity hold");
    property p_par_drv;
        adUpperOe |=> parUpperOe;
    endproperty
    a_par_drv: assert property (p_par_drv) else $error("parity late");
    property p_req_rel;
        $rose(primary_wide_request_n) |-> wideReqOe ##1 !wideReqOe;
    endproperty
    a_req_rel: assert property (p_req_rel) else $error("req release");
    property p_ack_rel;
        $rose(primary_wide_ack_n) |-> wideAckOe ##1 !wideAckOe;
    endproperty
    a_ack_rel: assert property (p_ack_rel) else $error("ack release");
    property p_ack_req;
        wideAckOe && !primary_wide_ack_n |-> !$past(wideReqNIn);
    endproperty
    a_ack_req: assert property (p_ack_req) else $error("ack no req");
    property p_ack_dev;
        wideAckOe && !primary_wide_ack_n |-> !$past(tgtDevselN);
    endproperty
    a_ack_dev: assert property (p_ack_dev) else $error("ack timing");
    property p_req_frame;
        wideReqOe && !primary_wide_request_n |-> !$past(mstFrameN);
    endproperty
    a_req_frame: assert property (p_req_frame) else $error("req");
    property p_narrow;
        !wideEnabled && $past(rst_n, 3) |-> adUpperOe && primary_wide_request_n;
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow park");
    c_req: cover property (!primary_wide_request_n);
    c_ack: cover property (!primary_wide_ack_n);
    c_rel: cover property ($fell(adUpperOe));
endmodule // pbx_ext64_asserts

bind pbx_ext64 pbx_ext64_asserts u_chk (.*);

// ### pbx_far_agent.sv
`timescale 1ns/1ps
module pbx_far_agent (
    input  wire logic        ref_clk,
    input  wire logic        farReqN,
    input  wire logic        rdDrive,
    input  wire logic        badPar,
    input  wire logic [31:0] rdData,
    input  wire logic [31:0] adUpperOut,
    input  wire logic        adUpperOe,
    input  wire logic [3:0]  primary_upper_cmd_byte_en,
    input  wire logic        primary_upper_parity,
    input  wire logic        parUpperOe,
    input  wire logic        primary_wide_request_n,
    input  wire logic        wideReqOe,
    output logic      [31:0] adUpperIn,
    output logic             parUpperIn,
    output logic             wideReqNIn
);
    logic drvPar_q;
    logic parVal_q;
    assign adUpperIn = adUpperOe ? adUpperOut : (rdDrive ? rdData : '1);
    always_ff @(posedge ref_clk)
    begin
        drvPar_q <= rdDrive && !adUpperOe;
        parVal_q <= ^{rdData, primary_upper_cmd_byte_en} ^ badPar;
    end
    assign parUpperIn = parUpperOe ? primary_upper_parity
                                   : (drvPar_q ? parVal_q : 1'h1);
    assign wideReqNIn = wideReqOe ? primary_wide_request_n : farReqN;
endmodule // pbx_far_agent

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic ref_clk, rst_n, mstFrameN, mstWantWide, mstDualAddr, mstAddrPhase;
    logic mstSecondAddr, mstDataPhase, mstWrite, tgtDevselN, tgtCanWide;
    logic tgtReadPhase, busGnt, busIdle, dataXfer, adUpperOe, cbeUpperOe;
    logic parUpperIn, primary_upper_parity, parUpperOe, wideReqNIn, wideReqOe;
    logic primary_wide_request_n, wideAckNIn, primary_devsel_n, wideAckOe;
    logic primary_wide_ack_n, wideEnabled, upperParErr, wideActive;
    logic farReqN, farAckN, rdDrive, badPar, err;
    logic [31:0] mstUpperAddr, mstUpperWrData, tgtUpperRdData, adUpperIn;
    logic [31:0] adUpperOut, rdUpperData, rdData, a, d;
    logic [3:0] mstCommand, mstUpperBe, cbeUpperIn, primary_upper_cmd_byte_en;
    int n_errors, compares, k, seed;
    assign cbeUpperIn = cbeUpperOe ? primary_upper_cmd_byte_en : 4'hf;
    assign wideAckNIn = wideAckOe ? primary_wide_ack_n : farAckN;
    assign primary_devsel_n = farAckN;
    pbx_ext64 u_dut (.*);
    pbx_far_agent u_far (.*);
    always #12.5 ref_clk = ~ref_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic do_reset(input logic narrow);
        @(posedge ref_clk);
        farReqN <= narrow;
        rst_n <= 1'h0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge ref_clk);
        farReqN <= 1'h1;
        @(posedge ref_clk);
        #1;
        check(wideEnabled, !narrow);
        check(adUpperOe, narrow);
    endtask
    task automatic xfer(input logic wr, input logic bad);
        a = $random(seed);
        d = $random(seed);
        @(posedge ref_clk);
        {mstFrameN, busIdle} <= 2'h0;
        {mstWantWide, mstDualAddr, mstAddrPhase} <= 3'h7;
        {mstUpperAddr, mstCommand} <= {a, pbx_pkg::CmdDualAddr};
        @(posedge ref_clk);
        mstSecondAddr <= 1'h1;
        #1;
        check(adUpperOut, a);
        check(primary_upper_cmd_byte_en, pbx_pkg::CmdDualAddr);
        check(primary_wide_request_n, 1'h0);
        @(posedge ref_clk);
        {mstAddrPhase, mstDataPhase, dataXfer, farAckN} <= 4'h6;
        {mstWrite, rdDrive, badPar} <= {wr, !wr, bad};
        {mstUpperWrData, rdData, mstUpperBe} <= {d, d, d[3:0]};
        mstSecondAddr <= 1'h0;
        #1;
        check({parUpperOe, primary_upper_parity},
              {1'h1, ^{a, pbx_pkg::CmdDualAddr}});
        @(posedge ref_clk);
        #1;
        err = 1'h0;
        check(wideActive, 1'h1);
        check({parUpperOe, primary_upper_parity},
              {1'h1, ^{pbx_pkg::ParkData, pbx_pkg::ParkCbe}});
        if (wr) check(adUpperOut, d);
        check(primary_upper_cmd_byte_en, d[3:0]);
        for (k = 0; k < 3; k++)
        begin
            @(posedge ref_clk);
            #1;
            if (k == 0 && wr)
                check({parUpperOe, primary_upper_parity},
                      {1'h1, ^{d, d[3:0]}});
            err = err | upperParErr;
        end
        check(err, !wr && bad);
        if (!wr) check(rdUpperData, d);
        @(posedge ref_clk);
        {mstFrameN, busIdle, farAckN} <= 3'h7;
        {mstWantWide, mstDualAddr, mstDataPhase, dataXfer, rdDrive} <= 5'h0;
        @(posedge ref_clk);
        #1;
        check({wideReqOe, primary_wide_request_n}, 2'h3);
        @(posedge ref_clk);
        #1;
        check({wideReqOe, primary_wide_request_n}, 2'h1);
    endtask
    task automatic tgt(input logic req);
        @(posedge ref_clk);
        {farReqN, tgtDevselN, tgtCanWide, tgtReadPhase} <= {!req, 3'h3};
        tgtUpperRdData <= $random(seed);
        repeat (2) @(posedge ref_clk);
        #1;
        check(primary_wide_ack_n, !req);
        check(adUpperOut, req ? tgtUpperRdData : pbx_pkg::ParkData);
        check(cbeUpperOe, !req);
        check(wideActive, req);
        @(posedge ref_clk);
        {farReqN, tgtDevselN, tgtCanWide, tgtReadPhase} <= 4'hc;
        @(posedge ref_clk);
        #1;
        check({wideAckOe, primary_wide_ack_n}, {req, 1'h1});
        repeat (2) @(posedge ref_clk);
        #1;
        check(wideAckOe, 1'h0);
    endtask
    initial
    begin
        seed = 32'h8bd38e68;
        {ref_clk, rst_n, mstSecondAddr, mstDataPhase, mstWrite} = '0;
        {mstWantWide, mstDualAddr, mstAddrPhase, dataXfer, rdDrive} = '0;
        {badPar, tgtCanWide, tgtReadPhase, busIdle, err} = '0;
        {mstFrameN, tgtDevselN, farAckN, farReqN, busGnt} = '1;
        {mstUpperAddr, mstUpperWrData, tgtUpperRdData, rdData} = '0;
        {mstCommand, mstUpperBe} = '0;
        do_reset(1'h0);
        xfer(1'h1, 1'h0);
        xfer(1'h0, 1'h1);
        for (int i = 0; i < 8; i++)
            xfer($random(seed), $random(seed));
        tgt(1'h1);
        tgt(1'h0);
        do_reset(1'h1);
        @(posedge ref_clk);
        mstFrameN <= 1'h0;
        mstWantWide <= 1'h1;
        repeat (3) @(posedge ref_clk);
        #1;
        check(primary_wide_request_n, 1'h1);
        report_and_stop();
    end
endmodule // tb_top
